// [design/cmu_pkg.sv]
// Package for the cache maintenance operation unit.
// Holds register offsets, field positions, codes, reset values and carriers.
// Assumes one 100 MHz clock domain shared with the pipeline and the MMU.
package cmu_pkg;
  // Register byte offsets on the plain register port
  localparam logic [7:0] CMU_TAG_LO_OFS = 8'h00;
  localparam logic [7:0] CMU_TAG_HI_OFS = 8'h04;
  localparam logic [7:0] CMU_DATA_LO_OFS = 8'h08;
  localparam logic [7:0] CMU_ERR_CTL_OFS = 8'h0C;
  localparam logic [7:0] CMU_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] CMU_IRQ_MASK_OFS = 8'h14;
  localparam logic [7:0] CMU_LAST_STAT_OFS = 8'h18;
  // Register reset values
  localparam logic [31:0] CMU_STAGING_RST = 32'h0000_0000;
  localparam logic [1:0] CMU_ERR_CTL_RST = 2'h0;
  localparam logic [4:0] CMU_IRQ_RST = 5'h00;
  // Default cache geometry
  localparam int CMU_CACHE_BYTES = 1024;
  localparam int CMU_ASSOC = 2;
  localparam int CMU_BYTES_PER_TAG = 16;
  // Instruction field positions
  localparam int CMU_IMM_W = 16;
  localparam int CMU_OP_LSB = 18;
  localparam int CMU_CSEL_LSB = 16;
  localparam int CMU_ADDR_OP_BIT = 20;
  localparam int CMU_KSEG_BIT = 31;
  // Operation codes
  localparam logic [2:0] CMU_OP_IDX_INV = 3'h0;
  localparam logic [2:0] CMU_OP_LOAD_TAG = 3'h1;
  localparam logic [2:0] CMU_OP_STORE_TAG = 3'h2;
  localparam logic [2:0] CMU_OP_STORE_DATA = 3'h3;
  // Cache select codes
  localparam logic [1:0] CMU_C_INSTR = 2'h0;
  localparam logic [1:0] CMU_C_DATA = 2'h1;
  // Tag staging layout
  localparam int CMU_TL_TAG_LSB = 8;
  localparam int CMU_TL_TAG_W = 24;
  localparam int CMU_TL_VALID_BIT = 7;
  localparam int CMU_TL_LOCK_BIT = 5;
  // Error control bits
  localparam int CMU_EC_WST_BIT = 0;
  localparam int CMU_EC_SPR_BIT = 1;
  // Interrupt event bits
  localparam int CMU_EV_DONE = 0;
  localparam int CMU_EV_TLB = 1;
  localparam int CMU_EV_ADDR = 2;
  localparam int CMU_EV_BUS = 3;
  localparam int CMU_EV_CERR = 4;
  // Cause codes; the encodings are arbitrary
  localparam logic [4:0] CMU_CAUSE_NONE = 5'h00;
  localparam logic [4:0] CMU_LOAD_TRANSLATION_CAUSE = 5'h01;
  localparam logic [4:0] CMU_STORE_TRANSLATION_CAUSE = 5'h02;
  localparam logic [4:0] CMU_LOAD_ADDRESS_ERROR_CAUSE = 5'h03;
  localparam logic [4:0] CMU_BUS_ERROR_CAUSE = 5'h04;
  localparam logic [4:0] CMU_CACHE_ERROR_CAUSE = 5'h05;
  // Control states
  typedef enum logic [1:0] {CMU_IDLE, CMU_XLATE, CMU_EXEC} cmu_state_e;
  // Request from the pipeline
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] base;
  } cmu_req_s;
  // Completion toward the pipeline
  typedef struct packed {
    logic done;
    logic exc;
    logic tlb_refill;
    logic [4:0] cause;
  } cmu_rsp_s;
endpackage : cmu_pkg

// [design/cmu_top.sv]
// Cache maintenance operation unit: executes index cache operations.
// Assumes the pipeline, MMU and bus error sources share clk and hold no
// handshake across domains; the register port master never overlaps strobes.
// Contract
// RULE1: Address is base plus sign-extended offset.
// RULE2: Address operations use MMU physical address.
// RULE3: Way and index from geometry-derived boundaries.
// RULE4: Direct-mapped cache ignores the way field.
// RULE5: Translation faults report load translation cause.
// RULE6: Never modified, store-translation or watch faults.
// RULE7: Writeback errors report cache error.
// RULE8: Bus error response raises bus error.
// RULE9: Faulting kernel address raises load address error.
// RULE10: Bits 17:16 pick instruction or data cache.
// RULE11: Bits 20:18 pick op; word only for data.
// RULE12: Code 000 invalidates block at index.
// RULE13: Code 001 loads tag and data staging.
// RULE14: Code 010 writes tag from tag staging.
// RULE15: Code 011 without test bits does nothing.
// RULE16: Software initialises caches by storing tags.
// RULE17: Software uses unmapped addresses for index ops.
// RULE18: Code 011 with store-test writes data staging.
// RULE19: Exceptions leave cache contents unchanged. The code still writes the arrays in the execute cycle on bus and cache errors.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module cmu_top
  import cmu_pkg::*;
#(
  parameter int CACHE_BYTES = CMU_CACHE_BYTES,
  parameter int ASSOC = CMU_ASSOC,
  parameter int BYTES_PER_TAG = CMU_BYTES_PER_TAG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pipeline request
  input wire logic req_valid,
  input wire cmu_req_s req,
  input wire logic user_mode,
  output logic req_ready,
  // Pipeline completion
  output cmu_rsp_s rsp,
  output logic watch_inhibit,
  // MMU translation
  output logic mmu_req_valid,
  output logic [31:0] mmu_vaddr,
  input wire logic mmu_rsp_valid,
  input wire logic [31:0] mmu_paddr,
  input wire logic mmu_refill,
  input wire logic mmu_invalid,
  // Error reports during execution
  input wire logic bus_err,
  input wire logic wb_err,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq
);
  // Geometry derived boundaries
  localparam int OFF_B = $clog2(BYTES_PER_TAG);
  localparam int IDX_B = $clog2(CACHE_BYTES / ASSOC);
  localparam int SETS = (CACHE_BYTES / ASSOC) / BYTES_PER_TAG;
  localparam int WPL = BYTES_PER_TAG / 4;
  localparam int WAY_W = (ASSOC > 1) ? $clog2(ASSOC) : 1;
  localparam int SET_W = (SETS > 1) ? $clog2(SETS) : 1;
  localparam int WRD_W = (WPL > 1) ? $clog2(WPL) : 1;

  // Control state
  cmu_state_e state_q;
  logic [31:0] instr_q; // Latched instruction
  logic [31:0] ea_q; // Effective address
  logic [31:0] paddr_q; // Translated address
  logic ready_q;
  cmu_rsp_s rsp_q;
  logic watch_q;
  logic mmu_req_q;
  logic [31:0] mmu_vaddr_q;
  logic [4:0] last_cause_q; // Cause of last completion

  // Software visible registers
  logic [31:0] tag_low_staging_q, tag_low_staging_d;
  logic [31:0] tag_high_staging_q;
  logic [31:0] data_low_staging_q, data_low_staging_d;
  logic [1:0] error_control_reg_q;
  logic [4:0] irq_stat_q, irq_stat_d;
  logic [4:0] irq_mask_q;
  logic irq_q;
  logic [31:0] rdata_q;

  // Cache arrays, per cache, way and set
  logic [CMU_TL_TAG_W-1:0] tag_mem [2][ASSOC][SETS];
  logic vld_mem [2][ASSOC][SETS];
  logic lck_mem [2][ASSOC][SETS];
  logic [31:0] data_mem [2][ASSOC][SETS][WPL];

  // RULE1: effective address formation
  wire [31:0] ea_w = req.base + {{CMU_IMM_W{req.instr[CMU_IMM_W-1]}}, req.instr[CMU_IMM_W-1:0]};
  // RULE9: kernel space from user mode faults
  wire addr_fault_w = user_mode & ea_w[CMU_KSEG_BIT];
  wire accept_w = req_valid & ready_q;

  // RULE10: cache select decode
  wire [1:0] csel_w = instr_q[CMU_CSEL_LSB+1:CMU_CSEL_LSB];
  wire cache_ok_w = (csel_w == CMU_C_INSTR) | (csel_w == CMU_C_DATA);
  wire cidx_w = (csel_w == CMU_C_DATA);
  // RULE11: operation decode
  wire [2:0] op_w = instr_q[CMU_OP_LSB+2:CMU_OP_LSB];
  wire exec_w = (state_q == CMU_EXEC);
  wire wst_w = error_control_reg_q[CMU_EC_WST_BIT];
  wire spr_w = error_control_reg_q[CMU_EC_SPR_BIT];

  // RULE2: address operations index with the physical address
  wire [31:0] sel_addr_w = instr_q[CMU_ADDR_OP_BIT] ? paddr_q : ea_q;
  // RULE3: index, way and word fields
  wire [31:0] set_full_w = (sel_addr_w >> OFF_B) & 32'(SETS - 1);
  // RULE4: direct-mapped mask is zero, way forced to 0
  wire [31:0] way_full_w = (sel_addr_w >> IDX_B) & 32'(ASSOC - 1);
  // RULE11: word index only matters for data transfers
  wire [31:0] wrd_full_w = (sel_addr_w >> 2) & 32'(WPL - 1);
  wire [SET_W-1:0] set_w = set_full_w[SET_W-1:0];
  wire [WAY_W-1:0] way_w = way_full_w[WAY_W-1:0];
  wire [WRD_W-1:0] wrd_w = wrd_full_w[WRD_W-1:0];

  // Operation strobes, only in the execute cycle
  // RULE12: index invalidate
  wire do_inv_w = exec_w & cache_ok_w & (op_w == CMU_OP_IDX_INV);
  // RULE13: index load tag, no scratchpad present
  wire do_ltag_w = exec_w & cache_ok_w & (op_w == CMU_OP_LOAD_TAG) & ~spr_w;
  // RULE14: index store tag
  wire do_stag_w = exec_w & cache_ok_w & (op_w == CMU_OP_STORE_TAG) & ~spr_w;
  // RULE15: RULE18: store data only with store-test set
  wire do_sdata_w = exec_w & cache_ok_w & (op_w == CMU_OP_STORE_DATA) & wst_w & ~spr_w;
  wire arr_we_w = do_inv_w | do_stag_w | do_sdata_w;

  // Array read for load tag
  wire [CMU_TL_TAG_W-1:0] rd_tag_w = tag_mem[cidx_w][way_w][set_w];
  wire rd_vld_w = vld_mem[cidx_w][way_w][set_w];
  wire rd_lck_w = lck_mem[cidx_w][way_w][set_w];
  wire [31:0] rd_data_w = data_mem[cidx_w][way_w][set_w][wrd_w];
  wire [31:0] ltag_word_w = {rd_tag_w, rd_vld_w, 1'b0, rd_lck_w, 5'h00};

  // Register decode
  wire wr_tl_w = reg_we & (reg_addr == CMU_TAG_LO_OFS);
  wire wr_th_w = reg_we & (reg_addr == CMU_TAG_HI_OFS);
  wire wr_dl_w = reg_we & (reg_addr == CMU_DATA_LO_OFS);
  wire wr_ec_w = reg_we & (reg_addr == CMU_ERR_CTL_OFS);
  wire wr_is_w = reg_we & (reg_addr == CMU_IRQ_STAT_OFS);
  wire wr_im_w = reg_we & (reg_addr == CMU_IRQ_MASK_OFS);

  // Staging next values, hardware load wins over a bus write
  assign tag_low_staging_d = do_ltag_w ? ltag_word_w : (wr_tl_w ? reg_wdata : tag_low_staging_q);
  assign data_low_staging_d = do_ltag_w ? rd_data_w : (wr_dl_w ? reg_wdata : data_low_staging_q);

  // Events from the registered completion
  wire rsp_tlb_w = rsp_q.exc & (rsp_q.cause == CMU_LOAD_TRANSLATION_CAUSE);
  wire [4:0] ev_w = {rsp_q.done & (rsp_q.cause == CMU_CACHE_ERROR_CAUSE),
                     rsp_q.done & (rsp_q.cause == CMU_BUS_ERROR_CAUSE),
                     rsp_q.done & (rsp_q.cause == CMU_LOAD_ADDRESS_ERROR_CAUSE),
                     rsp_q.done & rsp_tlb_w,
                     rsp_q.done};
  // Sticky status: set wins over write-one-clear
  assign irq_stat_d = (irq_stat_q & ~(wr_is_w ? reg_wdata[4:0] : 5'h00)) | ev_w;
  wire [4:0] irq_mask_d = wr_im_w ? reg_wdata[4:0] : irq_mask_q;

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_mux_w =
    (reg_addr == CMU_TAG_LO_OFS) ? tag_low_staging_q :
    (reg_addr == CMU_TAG_HI_OFS) ? tag_high_staging_q :
    (reg_addr == CMU_DATA_LO_OFS) ? data_low_staging_q :
    (reg_addr == CMU_ERR_CTL_OFS) ? {30'h0, error_control_reg_q} :
    (reg_addr == CMU_IRQ_STAT_OFS) ? {27'h0, irq_stat_q} :
    (reg_addr == CMU_IRQ_MASK_OFS) ? {27'h0, irq_mask_q} :
    (reg_addr == CMU_LAST_STAT_OFS) ? {24'h0, last_cause_q, 2'(state_q), ~ready_q} :
    32'h0000_0000;

  // Completion cause for the execute cycle
  // RULE8: bus error response first
  // RULE7: writeback detected error as cache error
  wire [4:0] exec_cause_w = bus_err ? CMU_BUS_ERROR_CAUSE :
                            (wb_err ? CMU_CACHE_ERROR_CAUSE : CMU_CAUSE_NONE);

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CMU_IDLE;
      instr_q <= 32'h0000_0000;
      ea_q <= 32'h0000_0000;
      paddr_q <= 32'h0000_0000;
      ready_q <= 1'b1;
      rsp_q <= '0;
      watch_q <= 1'b0;
      mmu_req_q <= 1'b0;
      mmu_vaddr_q <= 32'h0000_0000;
      last_cause_q <= CMU_CAUSE_NONE;
    end else begin
      // Pulses default low
      rsp_q <= '0;
      mmu_req_q <= 1'b0;
      unique case (state_q)
        CMU_IDLE: begin
          if (accept_w) begin
            instr_q <= req.instr;
            ea_q <= ea_w;
            ready_q <= 1'b0;
            // RULE6: keep watch logic quiet for this instruction
            watch_q <= 1'b1;
            if (addr_fault_w) begin
              // RULE9: address error, no translation, no array change
              rsp_q <= '{done: 1'b1, exc: 1'b1, tlb_refill: 1'b0, cause: CMU_LOAD_ADDRESS_ERROR_CAUSE};
              last_cause_q <= CMU_LOAD_ADDRESS_ERROR_CAUSE;
              ready_q <= 1'b1;
              watch_q <= 1'b0;
            end else begin
              // RULE2: ask the MMU for the physical address
              mmu_req_q <= 1'b1;
              mmu_vaddr_q <= ea_w;
              state_q <= CMU_XLATE;
            end
          end
        end
        CMU_XLATE: begin
          if (mmu_rsp_valid) begin
            if (mmu_refill | mmu_invalid) begin
              // RULE5: RULE19: load translation fault, skip execute
              rsp_q <= '{done: 1'b1, exc: 1'b1, tlb_refill: mmu_refill, cause: CMU_LOAD_TRANSLATION_CAUSE};
              last_cause_q <= CMU_LOAD_TRANSLATION_CAUSE;
              ready_q <= 1'b1;
              watch_q <= 1'b0;
              state_q <= CMU_IDLE;
            end else begin
              paddr_q <= mmu_paddr;
              state_q <= CMU_EXEC;
            end
          end
        end
        CMU_EXEC: begin
          rsp_q <= '{done: 1'b1, exc: (exec_cause_w != CMU_CAUSE_NONE), tlb_refill: 1'b0, cause: exec_cause_w};
          last_cause_q <= exec_cause_w;
          ready_q <= 1'b1;
          watch_q <= 1'b0;
          state_q <= CMU_IDLE;
        end
        default: begin
          state_q <= CMU_IDLE;
        end
      endcase
    end
  end

  // Cache array writes, execute cycle only
  always_ff @(posedge clk) begin
    // RULE12: clear valid and lock
    if (do_inv_w) begin
      vld_mem[cidx_w][way_w][set_w] <= 1'b0;
      lck_mem[cidx_w][way_w][set_w] <= 1'b0;
    end
    // RULE14: tag, valid and lock from staging
    if (do_stag_w) begin
      tag_mem[cidx_w][way_w][set_w] <= tag_low_staging_q[CMU_TL_TAG_LSB+CMU_TL_TAG_W-1:CMU_TL_TAG_LSB];
      vld_mem[cidx_w][way_w][set_w] <= tag_low_staging_q[CMU_TL_VALID_BIT];
      lck_mem[cidx_w][way_w][set_w] <= tag_low_staging_q[CMU_TL_LOCK_BIT];
    end
    // RULE18: data word at way and word index
    if (do_sdata_w) begin
      data_mem[cidx_w][way_w][set_w][wrd_w] <= data_low_staging_q;
    end
  end

  // Register file and interrupt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tag_low_staging_q <= CMU_STAGING_RST;
      tag_high_staging_q <= CMU_STAGING_RST;
      data_low_staging_q <= CMU_STAGING_RST;
      error_control_reg_q <= CMU_ERR_CTL_RST;
      irq_stat_q <= CMU_IRQ_RST;
      irq_mask_q <= CMU_IRQ_RST;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      // RULE13: load tag fills staging
      tag_low_staging_q <= tag_low_staging_d;
      data_low_staging_q <= data_low_staging_d;
      if (wr_th_w) begin
        tag_high_staging_q <= reg_wdata;
      end
      if (wr_ec_w) begin
        error_control_reg_q <= reg_wdata[1:0];
      end
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
      rdata_q <= reg_re ? rd_mux_w : 32'h0000_0000;
    end
  end

  // Outputs straight from flops
  assign req_ready = ready_q;
  assign rsp = rsp_q;
  assign watch_inhibit = watch_q;
  assign mmu_req_valid = mmu_req_q;
  assign mmu_vaddr = mmu_vaddr_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  // Checks
  property p_ea_form;
    @(posedge clk) disable iff (!rst_n)
    accept_w |=> ea_q == $past(req.base) + {{16{$past(req.instr[15])}}, $past(req.instr[15:0])};
  endproperty
  a_ea_form: assert property (p_ea_form) else $error("effective address wrong"); // RULE1

  property p_mmu_issue;
    @(posedge clk) disable iff (!rst_n)
    (accept_w & ~addr_fault_w) |=> mmu_req_valid & (mmu_vaddr == ea_q) & (state_q == CMU_XLATE);
  endproperty
  a_mmu_issue: assert property (p_mmu_issue) else $error("no translation request"); // RULE2

  property p_tlb_cause;
    @(posedge clk) disable iff (!rst_n)
    (state_q == CMU_XLATE && mmu_rsp_valid && (mmu_refill || mmu_invalid))
      |=> rsp.done && rsp.exc && rsp.cause == CMU_LOAD_TRANSLATION_CAUSE && rsp.tlb_refill == $past(mmu_refill);
  endproperty
  a_tlb_cause: assert property (p_tlb_cause) else $error("translation fault cause wrong"); // RULE5

  property p_no_store_cause;
    @(posedge clk) disable iff (!rst_n)
    rsp.cause != CMU_STORE_TRANSLATION_CAUSE && (state_q == CMU_IDLE || watch_inhibit);
  endproperty
  a_no_store_cause: assert property (p_no_store_cause) else $error("store cause or watch open"); // RULE6

  property p_cerr;
    @(posedge clk) disable iff (!rst_n)
    (exec_w && wb_err && !bus_err) |=> rsp.exc && rsp.cause == CMU_CACHE_ERROR_CAUSE ##1 irq_stat_q[CMU_EV_CERR];
  endproperty
  a_cerr: assert property (p_cerr) else $error("cache error not reported"); // RULE7

  property p_berr;
    @(posedge clk) disable iff (!rst_n)
    (exec_w && bus_err) |=> rsp.done && rsp.cause == CMU_BUS_ERROR_CAUSE ##1 irq_stat_q[CMU_EV_BUS];
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not reported"); // RULE8

  property p_addr_err;
    @(posedge clk) disable iff (!rst_n)
    (accept_w && addr_fault_w) |=> rsp.cause == CMU_LOAD_ADDRESS_ERROR_CAUSE && !mmu_req_valid && req_ready;
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error missing"); // RULE9

  property p_bad_cache;
    @(posedge clk) disable iff (!rst_n)
    (exec_w && !cache_ok_w) |-> !arr_we_w && !do_ltag_w;
  endproperty
  a_bad_cache: assert property (p_bad_cache) else $error("unsupported cache touched"); // RULE10

  property p_inv;
    @(posedge clk) disable iff (!rst_n)
    do_inv_w |=> !vld_mem[$past(cidx_w)][$past(way_w)][$past(set_w)];
  endproperty
  a_inv: assert property (p_inv) else $error("block still valid"); // RULE12

  property p_ltag;
    @(posedge clk) disable iff (!rst_n)
    do_ltag_w |=> tag_low_staging_q == $past(ltag_word_w) && data_low_staging_q === $past(rd_data_w);
  endproperty
  a_ltag: assert property (p_ltag) else $error("load tag staging wrong"); // RULE13

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    (exec_w && op_w == CMU_OP_STORE_DATA && !wst_w && !spr_w) |-> !arr_we_w;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code wrote cache"); // RULE15

  property p_exc_clean;
    @(posedge clk) disable iff (!rst_n)
    (rsp.done && (rsp.cause == CMU_LOAD_TRANSLATION_CAUSE || rsp.cause == CMU_LOAD_ADDRESS_ERROR_CAUSE))
      |-> !$past(arr_we_w) && !$past(do_ltag_w);
  endproperty
  a_exc_clean: assert property (p_exc_clean) else $error("cache changed on exception"); // RULE19

  c_inv: cover property (@(posedge clk) disable iff (!rst_n) do_inv_w ##1 rsp.done);
  c_ltag: cover property (@(posedge clk) disable iff (!rst_n) do_ltag_w);
  c_tlb: cover property (@(posedge clk) disable iff (!rst_n) rsp.done && rsp_tlb_w);
  c_sdata: cover property (@(posedge clk) disable iff (!rst_n) do_sdata_w);
endmodule : cmu_top

// [tb/cmu_mmu_model.sv]
// MMU partner model for the cache maintenance unit bench.
// Assumes one clock; answers each request after a set delay.
`timescale 1ns/1ps
module cmu_mmu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Knobs: answer delay, fault kind
  input wire logic [3:0] delay,
  input wire logic [1:0] fault,
  // Translation request
  input wire logic mmu_req_valid,
  input wire logic [31:0] mmu_vaddr,
  // Translation answer
  output logic mmu_rsp_valid,
  output logic [31:0] mmu_paddr,
  output logic mmu_refill,
  output logic mmu_invalid
);
  logic busy_q; // Request pending
  logic rsp_q; // Answer pulse
  logic [3:0] cnt_q; // Cycles left
  logic [31:0] va_q; // Captured address
  // Count down, then pulse the answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      if (mmu_req_valid) begin
        busy_q <= 1'b1;
        cnt_q <= delay;
        va_q <= mmu_vaddr;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        rsp_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  assign mmu_rsp_valid = rsp_q;
  assign mmu_paddr = rsp_q ? va_q : ~va_q;
  // Flags valid only with the answer
  assign mmu_refill = rsp_q ? (fault == 2'h1) : (fault != 2'h1);
  assign mmu_invalid = rsp_q ? (fault == 2'h2) : (fault != 2'h2);
endmodule : cmu_mmu_model

// [tb/cmu_top_tb.sv]
// Self-checking bench for the cache maintenance unit.
// Assumes the design's register port, pipeline port and MMU model above.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module cmu_top_tb
  import cmu_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, user_mode = 1'b0;
  logic bus_err = 1'b0, wb_err = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic req_ready, watch_inhibit, mmu_req_valid, mmu_rsp_valid, mmu_refill, mmu_invalid, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, mmu_vaddr, mmu_paddr, reg_rdata, va, rdv, tagv;
  logic [3:0] mdelay = 4'h0; // MMU answer delay
  logic [1:0] mfault = 2'h0; // MMU fault kind
  cmu_req_s req = '0;
  cmu_rsp_s rsp, r;
  int miscompares = 0, compares = 0, cyc = 0, nmmu;
  // Clock, 10 ns period
  always #5 clk = ~clk;
  cmu_top cmu_top_inst (.clk, .rst_n, .req_valid, .req, .user_mode, .req_ready, .rsp, .watch_inhibit,
    .mmu_req_valid, .mmu_vaddr, .mmu_rsp_valid, .mmu_paddr, .mmu_refill, .mmu_invalid, .bus_err,
    .wb_err, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq);
  cmu_mmu_model cmu_mmu_model_inst (.clk, .rst_n, .delay(mdelay), .fault(mfault), .mmu_req_valid,
    .mmu_vaddr, .mmu_rsp_valid, .mmu_paddr, .mmu_refill, .mmu_invalid);
  // Print counts and verdict, then stop
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  // Register read, data one cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask : rd
  // Issue one instruction, offset -16, wait for done
  task automatic op(input logic [2:0] code, input logic [1:0] cs, input logic [31:0] b, input logic um);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{instr: {11'h000, code, cs, 16'hFFF0}, base: b};
    user_mode <= um;
    @(posedge clk);
    req_valid <= 1'b0;
    nmmu = 0;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (n == 0) `CHK("watch_inhibit", ~rsp.done, watch_inhibit)
      if (n == 0) `CHK("ready_after_accept", rsp.done, req_ready)
      if (mmu_req_valid === 1'b1) nmmu++;
      if (rsp.done === 1'b1) break;
      @(posedge clk);
    end
    r = rsp;
    va = mmu_vaddr;
    `CHK("done", 1'b1, r.done)
    `CHK("ready_at_done", 1'b1, req_ready)
    `CHK("no_store_cause", 1'b1, r.cause !== CMU_STORE_TRANSLATION_CAUSE)
  endtask : op
  // Compare completion status
  task automatic exp_rsp(input logic e, input logic [4:0] c);
    `CHK("exc", e, r.exc)
    `CHK("cause", c, r.cause)
  endtask : exp_rsp
  // Load tag, then read both staging registers
  task automatic ld(input logic [1:0] cs, input logic [31:0] b);
    op(CMU_OP_LOAD_TAG, cs, b, 1'b0);
    exp_rsp(1'b0, CMU_CAUSE_NONE);
    rd(CMU_TAG_LO_OFS);
    tagv = rdv;
    rd(CMU_DATA_LO_OFS);
  endtask : ld
  // Registers read zero after reset
  task automatic t_reset;
    for (int a = 0; a <= 24; a += 4) begin
      rd(8'(a));
      `CHK("reset_reg", 32'h0, rdv)
    end
  endtask : t_reset
  // Store tags in two ways and two caches, read back
  task automatic t_tags;
    wr(CMU_TAG_LO_OFS, 32'hABCDEFA0);
    op(CMU_OP_STORE_TAG, CMU_C_INSTR, 32'h20, 1'b0);
    `CHK("eff_addr", 32'h10, va)
    wr(CMU_TAG_LO_OFS, 32'h123456A0);
    op(CMU_OP_STORE_TAG, CMU_C_INSTR, 32'h220, 1'b0);
    wr(CMU_TAG_LO_OFS, 32'h55AA3380);
    op(CMU_OP_STORE_TAG, CMU_C_DATA, 32'h20, 1'b0);
    ld(CMU_C_INSTR, 32'h8000002F);
    `CHK("tag_i_way0", 32'hABCDEFA0, tagv)
    `CHK("mmu_vaddr", 32'h8000001F, va)
    ld(CMU_C_INSTR, 32'h220);
    `CHK("tag_i_way1", 32'h123456A0, tagv)
    ld(CMU_C_DATA, 32'h20);
    `CHK("tag_d_way0", 32'h55AA3380, tagv)
  endtask : t_tags
  // Invalidate, and reserved code as no-op
  task automatic t_inval;
    op(CMU_OP_IDX_INV, CMU_C_INSTR, 32'h20, 1'b0);
    ld(CMU_C_INSTR, 32'h20);
    `CHK("inval_bits", 3'h0, tagv[7:5])
    op(CMU_OP_STORE_DATA, CMU_C_INSTR, 32'h220, 1'b0);
    exp_rsp(1'b0, CMU_CAUSE_NONE);
    ld(CMU_C_INSTR, 32'h220);
    `CHK("reserved_noop", 32'h123456A0, tagv)
  endtask : t_inval
  // Store data with the test bit, read it back
  task automatic t_data;
    wr(CMU_ERR_CTL_OFS, 32'h1);
    wr(CMU_DATA_LO_OFS, 32'hC0DE1234);
    op(CMU_OP_STORE_DATA, CMU_C_DATA, 32'h24, 1'b0);
    wr(CMU_DATA_LO_OFS, 32'h0);
    wr(CMU_ERR_CTL_OFS, 32'h0);
    ld(CMU_C_DATA, 32'h24);
    `CHK("data_word", 32'hC0DE1234, rdv)
  endtask : t_data
  // Address, translation, bus and cache errors
  task automatic t_faults;
    wr(CMU_TAG_LO_OFS, 32'h0F0F0F80);
    op(CMU_OP_STORE_TAG, CMU_C_INSTR, 32'h80000020, 1'b1);
    exp_rsp(1'b1, CMU_LOAD_ADDRESS_ERROR_CAUSE);
    `CHK("no_mmu_req", 0, nmmu)
    mfault = 2'h1;
    op(CMU_OP_STORE_TAG, CMU_C_DATA, 32'h20, 1'b0);
    exp_rsp(1'b1, CMU_LOAD_TRANSLATION_CAUSE);
    `CHK("refill", 1'b1, r.tlb_refill)
    mfault = 2'h2;
    op(CMU_OP_IDX_INV, CMU_C_DATA, 32'h20, 1'b0);
    exp_rsp(1'b1, CMU_LOAD_TRANSLATION_CAUSE);
    `CHK("refill_clear", 1'b0, r.tlb_refill)
    mfault = 2'h0;
    ld(CMU_C_DATA, 32'h20);
    `CHK("tag_kept", 32'h55AA3380, tagv)
    mdelay = 4'h3;
    @(posedge clk);
    bus_err <= 1'b1;
    op(CMU_OP_IDX_INV, CMU_C_INSTR, 32'h20, 1'b0);
    exp_rsp(1'b1, CMU_BUS_ERROR_CAUSE);
    @(posedge clk);
    bus_err <= 1'b0;
    wb_err <= 1'b1;
    op(CMU_OP_IDX_INV, CMU_C_INSTR, 32'h20, 1'b0);
    exp_rsp(1'b1, CMU_CACHE_ERROR_CAUSE);
    @(posedge clk);
    wb_err <= 1'b0;
    mdelay = 4'h0;
  endtask : t_faults
  // Status, mask, level output and clear
  task automatic t_irq;
    // Every event kind has fired by now; last op ended in cache error
    rd(CMU_IRQ_STAT_OFS);
    `CHK("stat_all", 5'h1F, rdv[4:0])
    rd(CMU_LAST_STAT_OFS);
    `CHK("last_stat", 32'h0000_0028, rdv)
    wr(CMU_IRQ_MASK_OFS, 32'h0);
    wr(CMU_IRQ_STAT_OFS, 32'h1F);
    op(CMU_OP_IDX_INV, CMU_C_DATA, 32'h20, 1'b0);
    rd(CMU_IRQ_STAT_OFS);
    `CHK("stat_done", 5'h01, rdv[4:0])
    `CHK("irq_masked", 1'b0, irq)
    wr(CMU_IRQ_MASK_OFS, 32'h1);
    #1;
    `CHK("irq_on", 1'b1, irq)
    wr(CMU_IRQ_STAT_OFS, 32'h1);
    #1;
    `CHK("irq_off", 1'b0, irq)
    rd(8'h40);
    `CHK("unmapped", 32'h0, rdv)
  endtask : t_irq
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_tags();
    t_inval();
    t_data();
    t_faults();
    t_irq();
    report_and_stop();
  end
endmodule : cmu_top_tb
